// ==== design/sbr_defs.svh ====
// Constants for the serial bridge control register bank.
// Assumes inclusion by bare name from design files.
`ifndef SBR_DEFS_SVH
`define SBR_DEFS_SVH
`define SBR_NUM_CTRL      14
`define SBR_NUM_CHAR      12
`define SBR_IDX_W         4
`define SBR_REPORT_HI     4'h3
`define SBR_RST_CLOSED    4'h0
`define SBR_RST_A_OPEN    4'hD
`define SBR_RST_B_OPEN    4'h5
`define SBR_RST_C_OPEN    4'h2
`define SBR_IDX_COND_A    4'h0
`define SBR_IDX_COND_B    4'h1
`define SBR_IDX_COND_C    4'h2
`define SBR_BIT_GATE      3
`define SBR_BIT_DATA_ERR  2
`define SBR_BIT_OVERFLOW  0
`define SBR_BIT_MANUAL    2
`define SBR_BIT_AUTODISC  1
`define SBR_BIT_BREAK     0
`endif

// ==== design/sbr_pkg.sv ====
// Types for the serial bridge control register bank.
// Assumes sbr_defs.svh is compiled alongside.
package sbr_pkg;
    typedef enum logic [1:0] {
        SBR_IDLE  = 2'b00,
        SBR_WRITE = 2'b01,
        SBR_READ  = 2'b11
    } sbr_mode_t;
endpackage

// ==== design/sbr_regs.sv ====
// Control and character register bank of the serial loop bridge.
// Assumes the loop decoder presents commands and data bytes as one-cycle strobes on clk_sys.
// Functional notes
// - Fourteen control registers, indices 0 to 13, each hold four bits.
// - A written control byte keeps only its low nibble.
// - A reported control register reads as 0011 above its nibble.
// - Twelve eight-bit character registers hold the special characters.
// - Gate bit 3 of request register A low blocks every service request.
// - Bit 2 of register A enables requests on receive data errors.
// - Bit 0 of register A enables requests on lost data; bit 1 does nothing.
// - Bits 3 to 0 of register B enable rx full, rx not empty, tx not full, tx empty.
// - Register B and C conditions request only while the gate bit is 1.
// - With the request switch closed the three request registers reset to 0000.
// - With the switch open they reset to 1101, 0101 and 0010.
// - Register C bits 2, 1, 0 enable manual key, autodisconnect and break; bit 3 unused.
// - After listener command 0, up to fourteen data bytes fill registers 0 to 13 in order.
// - After talker command 0, a send request outputs registers 0 to 13 in order then ends, or ends early on not_ready.
`timescale 1ns/1ps
`include "sbr_defs.svh"
module sbr_regs
#(
    parameter int NUM_CTRL = `SBR_NUM_CTRL,
    parameter int NUM_CHAR = `SBR_NUM_CHAR
)
(
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       arst_n,
    // Request switch strap, open when high
    input  wire logic       srq_switch_open,
    // Loop command strobes
    input  wire logic       listen_set_ctrl,
    input  wire logic       listen_set_char,
    input  wire logic       talk_send_ctrl,
    input  wire logic       talk_send_char,
    input  wire logic       new_listen,
    input  wire logic       send_data_req,
    input  wire logic       not_ready,
    input  wire logic       data_in_valid,
    input  wire logic [7:0] data_in,
    // Outgoing data
    output logic            data_out_valid,
    output logic [7:0]      data_out,
    output logic            end_of_tx,
    // Request conditions
    input  wire logic       data_error,
    input  wire logic       overflow_lost,
    input  wire logic [3:0] buf_level,
    input  wire logic       manual_request_key,
    input  wire logic       autodisconnect,
    input  wire logic       break_received,
    // Request output and register view
    output logic            srq,
    output logic [3:0]      request_master_gate_view
);
    import sbr_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [3:0]           ctrl      [NUM_CTRL];
    logic [7:0]           chr       [NUM_CHAR];
    logic [3:0]           next_ctrl [NUM_CTRL];
    logic [7:0]           next_chr  [NUM_CHAR];
    sbr_mode_t            mode;
    sbr_mode_t            next_mode;
    logic                 is_char;
    logic                 next_is_char;
    logic [`SBR_IDX_W:0]  idx;
    logic [`SBR_IDX_W:0]  next_idx;
    logic                 sending;
    logic                 next_sending;
    logic                 next_dov;
    logic [7:0]           next_dout;
    logic                 next_eot;
    logic [1:0]           sw_sync;
    logic                 sw_loaded;
    logic                 next_sw_loaded;
    logic [1:0]           sw_cnt;
    logic                 sw_valid;
    logic                 limit_hit;
    logic [`SBR_IDX_W:0]  limit;
    logic [1:0]           ev_sync [3];
    logic [2:0]           ev_now;

    assign limit = is_char ? (`SBR_IDX_W+1)'(NUM_CHAR) : (`SBR_IDX_W+1)'(NUM_CTRL);
    assign limit_hit = (idx + 1'b1) >= limit;

    // ----------------------------------------------------------------
    // Command sequencing and register updates
    // ----------------------------------------------------------------
    always_comb
    begin
        next_mode    = mode;
        next_is_char = is_char;
        next_idx     = idx;
        next_sending = sending;
        next_dov     = 1'b0;
        next_dout    = data_out;
        next_eot     = 1'b0;
        next_sw_loaded = sw_loaded | sw_valid;
        for (int i = 0; i < NUM_CTRL; i++)
            next_ctrl[i] = ctrl[i];
        for (int i = 0; i < NUM_CHAR; i++)
            next_chr[i] = chr[i];
        if (!sw_loaded)
        begin
            // Strap is only valid once synchronised, so the defaults load after release.
            next_ctrl[0] = sw_sync[1] ? `SBR_RST_A_OPEN : `SBR_RST_CLOSED;
            next_ctrl[1] = sw_sync[1] ? `SBR_RST_B_OPEN : `SBR_RST_CLOSED;
            next_ctrl[2] = sw_sync[1] ? `SBR_RST_C_OPEN : `SBR_RST_CLOSED;
        end
        else if (new_listen)
        begin
            next_mode    = listen_set_ctrl || listen_set_char ? SBR_WRITE : SBR_IDLE;
            next_is_char = listen_set_char;
            next_idx     = '0;
        end
        else if (talk_send_ctrl || talk_send_char)
        begin
            next_mode    = SBR_READ;
            next_is_char = talk_send_char;
            next_idx     = '0;
            next_sending = 1'b0;
        end
        else
        begin
            unique case (mode)
                SBR_IDLE:
                    next_sending = 1'b0;
                SBR_WRITE:
                    if (data_in_valid)
                    begin
                        if (is_char)
                            next_chr[idx[3:0]] = data_in;
                        else
                            next_ctrl[idx[3:0]] = data_in[3:0];
                        next_idx = idx + 1'b1;
                        if (limit_hit)
                            next_mode = SBR_IDLE;
                    end
                SBR_READ:
                    if (sending && not_ready)
                    begin
                        next_eot     = 1'b1;
                        next_mode    = SBR_IDLE;
                        next_sending = 1'b0;
                    end
                    else if (sending || send_data_req)
                    begin
                        next_sending = 1'b1;
                        next_dov     = 1'b1;
                        next_dout    = is_char ? chr[idx[3:0]] : {`SBR_REPORT_HI, ctrl[idx[3:0]]};
                        next_idx     = idx + 1'b1;
                        if (limit_hit)
                        begin
                            next_eot     = 1'b1;
                            next_mode    = SBR_IDLE;
                            next_sending = 1'b0;
                        end
                    end
                default:
                    next_mode = SBR_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mode           <= SBR_IDLE;
            is_char        <= 1'b0;
            idx            <= '0;
            sending        <= 1'b0;
            data_out_valid <= 1'b0;
            data_out       <= 8'h00;
            end_of_tx      <= 1'b0;
            sw_loaded      <= 1'b0;
            for (int i = 0; i < NUM_CTRL; i++)
                ctrl[i] <= 4'h0;
            for (int i = 0; i < NUM_CHAR; i++)
                chr[i] <= 8'h00;
        end
        else
        begin
            mode           <= next_mode;
            is_char        <= next_is_char;
            idx            <= next_idx;
            sending        <= next_sending;
            data_out_valid <= next_dov;
            data_out       <= next_dout;
            end_of_tx      <= next_eot;
            sw_loaded      <= next_sw_loaded;
            for (int i = 0; i < NUM_CTRL; i++)
                ctrl[i] <= next_ctrl[i];
            for (int i = 0; i < NUM_CHAR; i++)
                chr[i] <= next_chr[i];
        end
    end

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    assign sw_valid = sw_cnt[1];

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sw_sync <= 2'b00;
            sw_cnt  <= 2'b00;
        end
        else
        begin
            sw_sync <= {sw_sync[0], srq_switch_open};
            sw_cnt  <= sw_valid ? sw_cnt : sw_cnt + 2'b01;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_ev
            logic ev_pin;
            assign ev_pin = (g == 0) ? break_received : (g == 1) ? autodisconnect : manual_request_key;
            always_ff @(posedge clk_sys or negedge arst_n)
            begin
                if (!arst_n)
                    ev_sync[g] <= 2'b00;
                else
                    ev_sync[g] <= {ev_sync[g][0], ev_pin};
            end
            assign ev_now[g] = ev_sync[g][1];
        end
    endgenerate

    // ----------------------------------------------------------------
    // Service request
    // ----------------------------------------------------------------
    sbr_srq u_srq
    (
        .clk_sys       (clk_sys),
        .arst_n        (arst_n),
        .cond_a        (ctrl[`SBR_IDX_COND_A]),
        .cond_b        (ctrl[`SBR_IDX_COND_B]),
        .cond_c        (ctrl[`SBR_IDX_COND_C]),
        .data_error    (data_error),
        .overflow_lost (overflow_lost),
        .buf_level     (buf_level),
        .events        (ev_now),
        .srq           (srq)
    );

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            request_master_gate_view <= 4'h0;
        else
            request_master_gate_view <= ctrl[`SBR_IDX_COND_A];
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_report_hi;
        @(posedge clk_sys) disable iff (!arst_n)
        (data_out_valid && !is_char && mode != SBR_IDLE) |-> data_out[7:4] == `SBR_REPORT_HI;
    endproperty
    a_report_hi: assert property (p_report_hi) else $error("control report upper nibble wrong");

    property p_write_nibble;
        @(posedge clk_sys) disable iff (!arst_n)
        (sw_loaded && !new_listen && !talk_send_ctrl && !talk_send_char && mode == SBR_WRITE
         && !is_char && data_in_valid && idx == 0) |=> ctrl[0] == $past(data_in[3:0]);
    endproperty
    a_write_nibble: assert property (p_write_nibble) else $error("control write not low nibble");

    property p_write_stop;
        @(posedge clk_sys) disable iff (!arst_n)
        (mode == SBR_WRITE && !is_char && data_in_valid && idx == 13 && !new_listen
         && !talk_send_ctrl && !talk_send_char) |=> mode == SBR_IDLE;
    endproperty
    a_write_stop: assert property (p_write_stop) else $error("write did not stop after last register");

    property p_reset_defaults;
        @(posedge clk_sys) disable iff (!arst_n)
        $rose(sw_loaded) |-> ctrl[0] == (sw_sync[1] ? 4'hD : 4'h0) || $past(sw_sync[1]) != sw_sync[1];
    endproperty
    a_reset_defaults: assert property (p_reset_defaults) else $error("request register default wrong");

    property p_gate_top;
        @(posedge clk_sys) disable iff (!arst_n)
        (!ctrl[`SBR_IDX_COND_A][`SBR_BIT_GATE] ##1 !ctrl[`SBR_IDX_COND_A][`SBR_BIT_GATE]) |-> !srq;
    endproperty
    a_gate_top: assert property (p_gate_top) else $error("request with gate closed");
endmodule

// ==== design/sbr_srq.sv ====
// Service request combiner for the three request condition registers.
// Assumes condition inputs are synchronous to clk_sys.
`timescale 1ns/1ps
`include "sbr_defs.svh"
module sbr_srq
(
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       arst_n,
    // Enables
    input  wire logic [3:0] cond_a,
    input  wire logic [3:0] cond_b,
    input  wire logic [3:0] cond_c,
    // Conditions
    input  wire logic       data_error,
    input  wire logic       overflow_lost,
    input  wire logic [3:0] buf_level,
    input  wire logic [2:0] events,
    // Result
    output logic            srq
);
    logic next_srq;
    logic any_cond;

    always_comb
    begin
        any_cond = (cond_a[`SBR_BIT_DATA_ERR] & data_error)
                 | (cond_a[`SBR_BIT_OVERFLOW] & overflow_lost)
                 | (|(cond_b & buf_level))
                 | (|(cond_c[2:0] & events));
        next_srq = cond_a[`SBR_BIT_GATE] & any_cond;
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            srq <= 1'b0;
        else
            srq <= next_srq;
    end

    property p_gate_blocks;
        @(posedge clk_sys) disable iff (!arst_n)
        !cond_a[`SBR_BIT_GATE] |=> !srq;
    endproperty
    a_gate_blocks: assert property (p_gate_blocks) else $error("srq raised with gate closed");

    property p_srq_tracks;
        @(posedge clk_sys) disable iff (!arst_n)
        1'b1 |=> srq == $past(cond_a[3] && ((cond_a[2] && data_error) || (cond_a[0] && overflow_lost)
                                || (|(cond_b & buf_level)) || (|(cond_c[2:0] & events))));
    endproperty
    a_srq_tracks: assert property (p_srq_tracks) else $error("srq not gate and conditions");

    property p_error_srq;
        @(posedge clk_sys) disable iff (!arst_n)
        (cond_a[3] && cond_a[2] && data_error) |=> srq;
    endproperty
    a_error_srq: assert property (p_error_srq) else $error("data error srq missing");

    property p_level_srq;
        @(posedge clk_sys) disable iff (!arst_n)
        (cond_a[3] && |(cond_b & buf_level)) |=> srq;
    endproperty
    a_level_srq: assert property (p_level_srq) else $error("buffer level srq missing");

    property p_event_srq;
        @(posedge clk_sys) disable iff (!arst_n)
        (cond_a[3] && |(cond_c[2:0] & events)) |=> srq;
    endproperty
    a_event_srq: assert property (p_event_srq) else $error("event srq missing");

    property p_ovf_srq;
        @(posedge clk_sys) disable iff (!arst_n)
        (cond_a[3] && cond_a[0] && overflow_lost) |=> srq;
    endproperty
    a_ovf_srq: assert property (p_ovf_srq) else $error("overflow srq missing");
endmodule

// ==== test/sbr_host_model.sv ====
// Loop controller model: issues register commands and collects reported bytes.
// Assumes the register bank samples its strobes on the rising edge of clk_sys.
`timescale 1ns/1ps
module sbr_host_model
(
    // Clock
    input  wire logic       clk_sys,
    // Commands toward the bank
    output logic            listen_set_ctrl,
    output logic            listen_set_char,
    output logic            talk_send_ctrl,
    output logic            talk_send_char,
    output logic            new_listen,
    output logic            send_data_req,
    output logic            not_ready,
    output logic            data_in_valid,
    output logic [7:0]      data_in,
    // Reported data
    input  wire logic       data_out_valid,
    input  wire logic [7:0] data_out,
    input  wire logic       end_of_tx
);
    logic [7:0] rd  [0:13];
    logic [7:0] num [0:13];
    int         cnt;
    int         late;
    logic       got_eot;
    logic       eot_last;

    initial
    begin
        {listen_set_ctrl, listen_set_char, talk_send_ctrl, talk_send_char} = 4'h0;
        {new_listen, send_data_req, not_ready, data_in_valid} = 4'h0;
        data_in = 8'h00;
    end

    // Listener command 0, or 2 for the character registers, arms the bank for register data.
    task automatic listen(input logic chr = 1'b0);
        @(posedge clk_sys);
        #1;
        new_listen      = 1'b1;
        listen_set_ctrl = !chr;
        listen_set_char = chr;
        @(posedge clk_sys);
        #1;
        new_listen      = 1'b0;
        listen_set_ctrl = 1'b0;
        listen_set_char = 1'b0;
    endtask

    task automatic put(input logic [7:0] b);
        @(posedge clk_sys);
        #1;
        data_in_valid = 1'b1;
        data_in       = b;
        @(posedge clk_sys);
        #1;
        data_in_valid = 1'b0;
        data_in       = ~b;
    endtask

    // Talker command 0 (or 2) then a send request; not_ready goes out once stop bytes arrived.
    task automatic read_all(input int stop, input logic chr = 1'b0);
        logic nr_done;
        nr_done  = 1'b0;
        cnt      = 0;
        late     = 0;
        got_eot  = 1'b0;
        eot_last = 1'b0;
        @(posedge clk_sys);
        #1;
        talk_send_ctrl = !chr;
        talk_send_char = chr;
        @(posedge clk_sys);
        #1;
        talk_send_ctrl = 1'b0;
        talk_send_char = 1'b0;
        send_data_req  = 1'b1;
        @(posedge clk_sys);
        #1;
        send_data_req = 1'b0;
        for (int n = 0; n < 24; n++)
        begin
            @(negedge clk_sys);
            if (data_out_valid === 1'b1 && got_eot)
                late++;
            else if (data_out_valid === 1'b1 && cnt < 14)
            begin
                rd[cnt]  = data_out;
                num[cnt] = data_out - 8'd48;
                cnt++;
            end
            if (end_of_tx === 1'b1 && !got_eot)
            begin
                got_eot  = 1'b1;
                eot_last = data_out_valid;
            end
            @(posedge clk_sys);
            #1;
            not_ready = (cnt == stop) && !nr_done;
            nr_done   = nr_done | not_ready;
        end
    endtask
endmodule

// ==== test/tb_serial_bridge_srq_control_regs.sv ====
// Self-checking bench for the control register bank and its request combiner.
// Assumes sbr_regs as top and sbr_host_model as the loop controller.
`timescale 1ns/1ps
module tb_serial_bridge_srq_control_regs;
    logic       clk_sys;
    logic       arst_n;
    logic       srq_switch_open;
    logic [8:0] cnd;
    logic       listen_set_ctrl;
    logic       listen_set_char;
    logic       talk_send_ctrl;
    logic       talk_send_char;
    logic       new_listen;
    logic       send_data_req;
    logic       not_ready;
    logic       data_in_valid;
    logic [7:0] data_in;
    logic       data_out_valid;
    logic [7:0] data_out;
    logic       end_of_tx;
    logic       srq;
    logic [3:0] request_master_gate_view;
    int         fail_count;
    int         checked;
    int         cycles;

    sbr_regs i_sbr_regs (.clk_sys(clk_sys), .arst_n(arst_n), .srq_switch_open(srq_switch_open),
        .listen_set_ctrl(listen_set_ctrl), .listen_set_char(listen_set_char),
        .talk_send_ctrl(talk_send_ctrl), .talk_send_char(talk_send_char), .new_listen(new_listen),
        .send_data_req(send_data_req), .not_ready(not_ready), .data_in_valid(data_in_valid),
        .data_in(data_in), .data_out_valid(data_out_valid), .data_out(data_out), .end_of_tx(end_of_tx),
        .data_error(cnd[8]), .overflow_lost(cnd[7]), .buf_level(cnd[6:3]), .manual_request_key(cnd[2]),
        .autodisconnect(cnd[1]), .break_received(cnd[0]), .srq(srq),
        .request_master_gate_view(request_master_gate_view));

    sbr_host_model i_sbr_host_model (.clk_sys(clk_sys), .listen_set_ctrl(listen_set_ctrl),
        .listen_set_char(listen_set_char), .talk_send_ctrl(talk_send_ctrl), .talk_send_char(talk_send_char),
        .new_listen(new_listen), .send_data_req(send_data_req), .not_ready(not_ready),
        .data_in_valid(data_in_valid), .data_in(data_in), .data_out_valid(data_out_valid),
        .data_out(data_out), .end_of_tx(end_of_tx));

    // ----------------------------------------------------------------
    // Clock, timeout and reporting
    // ----------------------------------------------------------------
    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // The full run needs about 640 cycles, so 20000 leaves a wide margin.
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            summarize();
        end
    end

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    // The strap is set before release so the bank captures it after reset.
    task automatic reset_dut(input logic open);
        arst_n          = 1'b0;
        srq_switch_open = open;
        repeat (4) @(posedge clk_sys);
        #1;
        arst_n = 1'b1;
        repeat (6) @(posedge clk_sys);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_defaults(input logic open);
        logic [3:0] e;
        reset_dut(open);
        i_sbr_host_model.read_all(99);
        chk(8'(i_sbr_host_model.cnt), 8'd14, "byte count");
        chk({7'h00, i_sbr_host_model.eot_last}, 8'h01, "end with last byte");
        chk({4'h0, request_master_gate_view}, open ? 8'h0D : 8'h00, "gate view");
        for (int k = 0; k < 14; k++)
        begin
            e = (!open || k > 2) ? 4'h0 : (k == 0) ? 4'hD : (k == 1) ? 4'h5 : 4'h2;
            chk(i_sbr_host_model.rd[k], {4'h3, e}, open ? "open default" : "closed default");
        end
    endtask

    // A fifteenth byte must not wrap around onto register 0.
    task automatic t_write();
        i_sbr_host_model.listen();
        for (int k = 0; k < 15; k++)
            i_sbr_host_model.put({~4'(k), 4'(k)});
        i_sbr_host_model.read_all(99);
        for (int k = 0; k < 14; k++)
        begin
            chk(i_sbr_host_model.rd[k], {4'h3, 4'(k)}, "stored nibble");
            chk(i_sbr_host_model.num[k], 8'(k), "numeric value");
        end
    endtask

    // Character registers report raw bytes, and a thirteenth byte must not wrap.
    task automatic t_chars();
        i_sbr_host_model.listen(1'b1);
        for (int k = 0; k < 13; k++)
            i_sbr_host_model.put(8'hA0 + 8'(k));
        i_sbr_host_model.read_all(99, 1'b1);
        chk(8'(i_sbr_host_model.cnt), 8'd12, "char byte count");
        for (int k = 0; k < 12; k++)
            chk(i_sbr_host_model.rd[k], 8'hA0 + 8'(k), "char register");
    endtask

    task automatic t_abort();
        i_sbr_host_model.read_all(3);
        chk({7'h00, i_sbr_host_model.got_eot}, 8'h01, "end after not ready");
        chk({7'h00, i_sbr_host_model.cnt < 14}, 8'h01, "short transfer");
        chk(8'(i_sbr_host_model.late), 8'h00, "bytes after end");
    endtask

    // Pin events pass a two-stage synchroniser, so five cycles cover every path.
    task automatic srq_case(input logic [3:0] a, b, c, input logic [8:0] cv, input logic exp);
        i_sbr_host_model.listen();
        i_sbr_host_model.put({4'h5, a});
        i_sbr_host_model.put({4'h5, b});
        i_sbr_host_model.put({4'h5, c});
        repeat (2) @(posedge clk_sys);
        #1;
        chk({4'h0, request_master_gate_view}, {4'h0, a}, "gate view");
        cnd = cv;
        repeat (5) @(posedge clk_sys);
        @(negedge clk_sys);
        chk({7'h00, srq}, {7'h00, exp}, "service request");
        @(posedge clk_sys);
        #1;
        cnd = 9'h000;
        repeat (5) @(posedge clk_sys);
    endtask

    task automatic t_srq();
        srq_case(4'h8, 4'h0, 4'h0, 9'h000, 1'b0);
        srq_case(4'hC, 4'h0, 4'h0, 9'h100, 1'b1);
        srq_case(4'h4, 4'hF, 4'h7, 9'h1FF, 1'b0);
        srq_case(4'h9, 4'h0, 4'h0, 9'h080, 1'b1);
        srq_case(4'hA, 4'h0, 4'h0, 9'h1FF, 1'b0);
        srq_case(4'h8, 4'h0, 4'h8, 9'h007, 1'b0);
        for (int i = 0; i < 4; i++)
        begin
            srq_case(4'h8, 4'h1 << i, 4'h0, 9'h008 << i, 1'b1);
            srq_case(4'h8, 4'h1 << i, 4'h0, 9'h078 & ~(9'h008 << i), 1'b0);
        end
        for (int i = 0; i < 3; i++)
        begin
            srq_case(4'h8, 4'h0, 4'h1 << i, 9'h001 << i, 1'b1);
            srq_case(4'h0, 4'h0, 4'h1 << i, 9'h001 << i, 1'b0);
        end
    endtask

    initial
    begin
        arst_n          = 1'b0;
        srq_switch_open = 1'b1;
        cnd             = 9'h000;
        fail_count      = 0;
        checked         = 0;
        cycles          = 0;
        t_defaults(1'b1);
        t_defaults(1'b0);
        t_write();
        t_abort();
        t_chars();
        t_srq();
        summarize();
    end
endmodule
